// File: sfs_flash_seq.sv
// command sequencer: unique id, security registers, reset, suspend, dpd
`timescale 1ns/1ps
`default_nettype none

// Function
// - unique id read: opcode, zero address, dummy, then 128-bit id until deselect.
// - three 1 KB security registers, address 00h, select 1..3, bits 11-10 zero.
// - secreg erase needs latch set and deselect right after 32nd bit.
// - accepted erase runs sector-erase time with busy set; latch cleared.
// - a locked security register ignores erase and program.
// - secreg program needs latch, address, one data byte; runs page-program time.
// - four pages per register, up to 256 bytes per program sequence.
// - secreg read: opcode, address, dummy sampled on rise; data shifts on fall.
// - read address increments, wraps 3FFh to 000h within register.
// - accepted reset aborts operations and clears all volatile state.
// - reset needs enable frame then reset frame, in either command mode.
// - after reset all commands refused for recovery time, longer after erase.
// - reset pair ignored in quad double-rate continuous read mode.
// - suspend accepted only during program or sector/block erase, not suspended.
// - suspend sets flag at once and clears busy within suspend latency.
// - program suspend rejects status write, secreg and array erase/program.
// - erase suspend rejects status write, secreg erase and array erase; the code also rejects secreg and array program.
// - resume only when suspended and idle; clears flag, busy back quickly.
// - deep power-down only by its opcode; then only release and reset work.
// - deselect with nothing running is standby, not deep power-down.
// - deep power-down refused while busy; needs deselect after 8 bits.
// - after release, commands refused for release recovery time.
module sfs_flash_seq
  import sfs_pkg::*;
#(
  parameter int SE_TIME_US = 50000,   // sector erase time
  parameter int PP_TIME_US = 1000,    // page program time
  parameter int RST_TIME_US = 40,     // reset recovery
  parameter int RST_E_TIME_US = 12000, // reset recovery after erase
  parameter int RES_TIME_US = 20      // release recovery
) (
  input wire logic clk_i,             // system clock, 50 MHz
  input wire logic rst_n_i,           // async reset, active low
  input wire logic cs_n_i,            // chip select pin, active low
  input wire logic sclk_i,            // serial clock pin
  input wire logic si_i,              // serial data in pin
  input wire logic [2:0] secreg_lock_i, // lock bits, register 3..1
  input wire logic crm_active_i,      // quad dtr continuous read active
  output logic so_o,                  // serial data out
  output logic so_oe_o,               // so driven when high
  output logic write_in_progress_o,   // self-timed cycle running
  output logic write_enable_latch_o,  // write latch
  output logic erase_suspend_flag_o,  // erase suspended
  output logic program_suspend_flag_o, // program suspended
  output logic deep_power_down_o,     // in deep power-down
  output logic standby_o,             // deselected and idle
  output logic soft_reset_o           // pulse: clear external volatile bits
);

  // long counts derived from the times at the clock rate
  localparam int unsigned SE_CYC = SE_TIME_US * CLK_MHZ;
  localparam int unsigned PP_CYC = PP_TIME_US * CLK_MHZ;
  localparam int unsigned RST_CYC = RST_TIME_US * CLK_MHZ;
  localparam int unsigned RSTE_CYC = RST_E_TIME_US * CLK_MHZ;
  localparam int unsigned RES_CYC = RES_TIME_US * CLK_MHZ;

  // -------------------------------------------------------------------
  // pins
  // -------------------------------------------------------------------
  logic cs_n;
  logic si;
  logic ck_rise;
  logic ck_fall;
  logic cs_rise;
  logic cs_fall;

  sfs_pin_sync u_sync (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .cs_n_i      (cs_n_i),
    .sclk_i      (sclk_i),
    .si_i        (si_i),
    .cs_n_o      (cs_n),
    .si_o        (si),
    .sclk_rise_o (ck_rise),
    .sclk_fall_o (ck_fall),
    .cs_rise_o   (cs_rise),
    .cs_fall_o   (cs_fall)
  );

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  sfs_mode_e mode_q, mode_d;
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] bits_q, bits_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] op_q, op_d;
  logic [23:0] adr_q, adr_d;
  logic [9:0] rd_q, rd_d;
  logic [3:0] uid_q, uid_d;
  logic [7:0] out_q, out_d;
  logic [7:0] pb_idx_q, pb_idx_d;
  logic [7:0] cur_q, cur_d;
  logic [1:0] cur_sel_q, cur_sel_d;
  logic [1:0] cur_pg_q, cur_pg_d;
  logic so_q, so_d;
  logic oe_q, oe_d;
  logic wel_q, wel_d;
  logic esus_q, esus_d;
  logic psus_q, psus_d;
  logic rst_en_q, rst_en_d;
  logic srst_q, srst_d;
  logic wip_q, stby_q, dpd_q;
  logic pb_clr, pb_we, done_erase, done_prog;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic [12:0] nb;
  logic one8, aligned, idle, start_ok, sr_ok, lock_hit;
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] pbuf_q [PAGE_BYTES];

  assign nb = bits_q[15:3];
  assign one8 = (bits_q == BITS_OPCODE);
  assign aligned = (bits_q[2:0] == 3'h0);
  assign idle = (mode_q == MD_IDLE);
  assign byte_in = {sr_q[6:0], si};
  assign sr_ok = secreg_addr_ok(adr_q);
  assign lock_hit = secreg_lock_i[secreg_sel(adr_q)];
  // new timed work only from idle: this also refuses every write-type
  // command while a program or erase stands suspended
  assign start_ok = idle && wel_q;
  assign rd_byte = (op_q == OP_UID) ?
                   UNIQUE_ID[{~uid_q, 3'h0} +: 8] :
                   mem_q[{secreg_sel(adr_q), rd_q}];

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    sr_d = sr_q;
    op_d = op_q;
    adr_d = adr_q;
    rd_d = rd_q;
    uid_d = uid_q;
    out_d = out_q;
    pb_idx_d = pb_idx_q;
    cur_d = cur_q;
    cur_sel_d = cur_sel_q;
    cur_pg_d = cur_pg_q;
    so_d = so_q;
    oe_d = oe_q;
    wel_d = wel_q;
    esus_d = esus_q;
    psus_d = psus_q;
    rst_en_d = rst_en_q;
    srst_d = 1'b0;
    pb_clr = 1'b0;
    pb_we = 1'b0;
    done_erase = 1'b0;
    done_prog = 1'b0;

    // self-timed cycle and recovery counters
    unique case (mode_q)
      MD_BUSY:
      begin
        if (cnt_q <= 32'h1)
        begin
          mode_d = MD_IDLE;
          done_erase = (cur_q == OP_SR_ERASE);
          done_prog = (cur_q == OP_SR_PROG);
        end
        else
          cnt_d = cnt_q - 32'h1;
      end
      MD_RECOVER:
      begin
        if (cnt_q <= 32'h1)
          mode_d = MD_IDLE;
        else
          cnt_d = cnt_q - 32'h1;
      end
      MD_IDLE, MD_SUSP, MD_DPD:
      begin
      end
    endcase

    if (cs_fall)
    begin
      bits_d = 16'h0;
      uid_d = 4'h0;
      pb_clr = idle;
    end

    // command, address and data bits are taken on sclk rise
    if (ck_rise && !cs_n)
    begin
      sr_d = byte_in;
      if (bits_q != 16'hFFFF)
        bits_d = bits_q + 16'h1;
      if (bits_q[2:0] == 3'h7)
      begin
        if (nb == 13'h0)
          op_d = byte_in;
        else if (nb < BYTES_PROG_HDR)
          adr_d = {adr_q[15:0], byte_in};
        if (nb == 13'h3)
        begin
          rd_d = {adr_q[1:0], byte_in};
          pb_idx_d = byte_in;
        end
        if (nb >= BYTES_PROG_HDR && op_q == OP_SR_PROG && idle)
        begin
          pb_we = 1'b1;
          pb_idx_d = pb_idx_q + 8'h1;
        end
      end
    end

    // read data shifts on sclk fall, a new byte at each boundary
    if (ck_fall && !cs_n && nb >= BYTES_READ_HDR &&
        (mode_q == MD_IDLE || mode_q == MD_SUSP) &&
        (op_q == OP_UID || (op_q == OP_SR_READ && sr_ok)))
    begin
      oe_d = 1'b1;
      if (aligned)
      begin
        so_d = rd_byte[7];
        out_d = {rd_byte[6:0], 1'b0};
        uid_d = uid_q + 4'h1;
        rd_d = rd_q + 10'h1;
      end
      else
      begin
        so_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
    end
    if (cs_n)
    begin
      oe_d = 1'b0;
      so_d = 1'b0;
    end

    // commands execute when chip select rises
    if (cs_rise && mode_q != MD_RECOVER)
    begin
      rst_en_d = 1'b0;
      if (one8 && op_q == OP_RST_EN && !crm_active_i)
        rst_en_d = 1'b1;
      else if (one8 && op_q == OP_RST && rst_en_q && !crm_active_i)
      begin
        mode_d = MD_RECOVER;
        cnt_d = (mode_q == MD_BUSY || mode_q == MD_SUSP) && !psus_q &&
                cur_q != OP_PP && cur_q != OP_QPP && cur_q != OP_SR_PROG ?
                RSTE_CYC : RST_CYC;
        cur_d = 8'h00;
        wel_d = 1'b0;
        esus_d = 1'b0;
        psus_d = 1'b0;
        srst_d = 1'b1;
      end
      else if (mode_q == MD_DPD)
      begin
        if (bits_q >= BITS_OPCODE && op_q == OP_RDP)
        begin
          mode_d = MD_RECOVER;
          cnt_d = RES_CYC;
        end
      end
      else
      begin
        unique case (op_q)
          OP_WRITE_ENABLE_CMD:
            if (one8 && mode_q != MD_BUSY)
              wel_d = 1'b1;
          OP_DPD:
            if (one8 && mode_q != MD_BUSY)
              mode_d = MD_DPD;
          OP_SUSP:
            if (one8 && mode_q == MD_BUSY && !esus_q && !psus_q)
            begin
              if (cur_q == OP_SE || cur_q == OP_BE32 || cur_q == OP_BE64)
              begin
                mode_d = MD_SUSP;
                esus_d = 1'b1;
              end
              else if (cur_q == OP_PP || cur_q == OP_QPP)
              begin
                mode_d = MD_SUSP;
                psus_d = 1'b1;
              end
            end
          OP_RESUME:
            if (one8 && mode_q == MD_SUSP)
            begin
              mode_d = MD_BUSY;
              esus_d = 1'b0;
              psus_d = 1'b0;
            end
          OP_SR_ERASE:
            if (bits_q == BITS_OP_ADDR && start_ok && sr_ok && !lock_hit)
            begin
              mode_d = MD_BUSY;
              cnt_d = SE_CYC;
              cur_d = op_q;
              cur_sel_d = secreg_sel(adr_q);
              wel_d = 1'b0;
            end
          OP_SR_PROG:
            if (aligned && nb >= BYTES_READ_HDR && start_ok && sr_ok &&
                !lock_hit)
            begin
              mode_d = MD_BUSY;
              cnt_d = PP_CYC;
              cur_d = op_q;
              cur_sel_d = secreg_sel(adr_q);
              cur_pg_d = adr_q[9:8];
              wel_d = 1'b0;
            end
          OP_SE, OP_BE32, OP_BE64:
            if (bits_q == BITS_OP_ADDR && start_ok)
            begin
              mode_d = MD_BUSY;
              cnt_d = SE_CYC;
              cur_d = op_q;
              wel_d = 1'b0;
            end
          OP_CE1, OP_CE2:
            if (one8 && start_ok)
            begin
              mode_d = MD_BUSY;
              cnt_d = SE_CYC;
              cur_d = op_q;
              wel_d = 1'b0;
            end
          OP_PP, OP_QPP:
            if (aligned && nb >= BYTES_READ_HDR && start_ok)
            begin
              mode_d = MD_BUSY;
              cnt_d = PP_CYC;
              cur_d = op_q;
              wel_d = 1'b0;
            end
          default:
          begin
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= MD_IDLE;
      cnt_q <= 32'h0;
      bits_q <= 16'h0;
      sr_q <= 8'h00;
      op_q <= 8'h00;
      adr_q <= 24'h0;
      rd_q <= 10'h0;
      uid_q <= 4'h0;
      out_q <= 8'h00;
      pb_idx_q <= 8'h00;
      cur_q <= 8'h00;
      cur_sel_q <= 2'h0;
      cur_pg_q <= 2'h0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      wel_q <= 1'b0;
      esus_q <= 1'b0;
      psus_q <= 1'b0;
      rst_en_q <= 1'b0;
      srst_q <= 1'b0;
      wip_q <= 1'b0;
      stby_q <= 1'b1;
      dpd_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      sr_q <= sr_d;
      op_q <= op_d;
      adr_q <= adr_d;
      rd_q <= rd_d;
      uid_q <= uid_d;
      out_q <= out_d;
      pb_idx_q <= pb_idx_d;
      cur_q <= cur_d;
      cur_sel_q <= cur_sel_d;
      cur_pg_q <= cur_pg_d;
      so_q <= so_d;
      oe_q <= oe_d;
      wel_q <= wel_d;
      esus_q <= esus_d;
      psus_q <= psus_d;
      rst_en_q <= rst_en_d;
      srst_q <= srst_d;
      wip_q <= (mode_d == MD_BUSY);
      stby_q <= cs_n && (mode_d == MD_IDLE || mode_d == MD_SUSP);
      dpd_q <= (mode_d == MD_DPD);
    end
  end

  // -------------------------------------------------------------------
  // security register storage
  // -------------------------------------------------------------------
  // programming only clears bits; an aborted cycle leaves the array as is
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
        mem_q[i] <= ERASED_BYTE;
      for (int i = 0; i < PAGE_BYTES; i++)
        pbuf_q[i] <= ERASED_BYTE;
    end
    else
    begin
      if (pb_clr)
        for (int i = 0; i < PAGE_BYTES; i++)
          pbuf_q[i] <= ERASED_BYTE;
      else if (pb_we)
        pbuf_q[pb_idx_q] <= byte_in;
      if (done_erase)
        for (int i = 0; i < SR_BYTES; i++)
          mem_q[{cur_sel_q, 10'(i)}] <= ERASED_BYTE;
      if (done_prog)
        for (int i = 0; i < PAGE_BYTES; i++)
          mem_q[{cur_sel_q, cur_pg_q, 8'(i)}] <=
            mem_q[{cur_sel_q, cur_pg_q, 8'(i)}] & pbuf_q[i];
    end
  end

  assign so_o = so_q;
  assign so_oe_o = oe_q;
  assign write_in_progress_o = wip_q;
  assign write_enable_latch_o = wel_q;
  assign erase_suspend_flag_o = esus_q;
  assign program_suspend_flag_o = psus_q;
  assign deep_power_down_o = dpd_q;
  assign standby_o = stby_q;
  assign soft_reset_o = srst_q;

endmodule // sfs_flash_seq

`default_nettype wire

// File: sfs_flash_seq_tb.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
  end

module sfs_flash_seq_tb
  import sfs_pkg::*;
;
  logic clk, rst_n, cs_n, sclk, si, so, oe;
  logic write_in_progress, write_enable_latch, esus, psus, dpd, stby, srst, crm;
  logic [2:0] lock;
  logic [7:0] rx[$];
  int err_total = 0;
  int compares = 0;
  int pulses = 0;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cycles: erase 250, program 150, reset 50, after erase 250, wake 1000
  // wake keeps its default, so the release delay is the real count
  sfs_flash_seq #(
    .SE_TIME_US(5), .PP_TIME_US(3), .RST_TIME_US(1),
    .RST_E_TIME_US(5)
  ) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
    .si_i(si), .secreg_lock_i(lock), .crm_active_i(crm), .so_o(so),
    .so_oe_o(oe), .write_in_progress_o(write_in_progress),
    .write_enable_latch_o(write_enable_latch), .erase_suspend_flag_o(esus),
    .program_suspend_flag_o(psus), .deep_power_down_o(dpd),
    .standby_o(stby), .soft_reset_o(srst)
  );
  sfs_host_model u_host (
    .clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si)
  );

  always @(posedge clk)
    if (srst === 1'b1)
      pulses++;

  // ------------------------------------------------------------------
  // helpers and scenarios
  // ------------------------------------------------------------------
  task automatic send(input logic [7:0] tx[$]);
    u_host.frame(tx, 0, rx);
  endtask

  task automatic op4(input logic [7:0] op, mid, input logic dat);
    logic [7:0] q[$];
    q = {op, 8'h00, mid, 8'h00};
    if (dat)
      q.push_back(8'h33);
    send(q);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("idle", 1'b0, write_in_progress)
  endtask

  task automatic t_uid();
    u_host.frame({OP_UID, 8'h00, 8'h00, 8'h00, 8'h00}, 17, rx);
    for (int i = 0; i < 17; i++)
      `CHK("uid", UNIQUE_ID[127 - 8 * (i % 16) -: 8], rx[i])
    `CHK("oe off", 1'b0, oe)
    $display("uid test done");
  endtask

  task automatic t_sec();
    op4(OP_SR_PROG, 8'h10, 1'b1);
    `CHK("no latch", 1'b0, write_in_progress)
    send({OP_WRITE_ENABLE_CMD});
    send({OP_SR_ERASE, 8'h00, 8'h20, 8'h00, 8'h00});
    `CHK("long erase", 1'b0, write_in_progress)
    op4(OP_SR_ERASE, 8'h40, 1'b0);
    `CHK("bad reg", 1'b0, write_in_progress)
    lock <= 3'h2;
    op4(OP_SR_ERASE, 8'h20, 1'b0);
    `CHK("locked", 1'b0, write_in_progress)
    lock <= 3'h5;
    op4(OP_SR_ERASE, 8'h10, 1'b0);
    `CHK("locked one", 1'b0, write_in_progress)
    op4(OP_SR_ERASE, 8'h30, 1'b0);
    `CHK("locked three", 1'b0, write_in_progress)
    op4(OP_SR_ERASE, 8'h20, 1'b0);
    `CHK("erase busy", 2'b10, {write_in_progress, write_enable_latch})
    wait_idle();
    send({OP_WRITE_ENABLE_CMD});
    send({OP_SR_PROG, 8'h00, 8'h20, 8'h00, 8'h5A});
    wait_idle();
    send({OP_WRITE_ENABLE_CMD});
    send({OP_SR_PROG, 8'h00, 8'h23, 8'hFF, 8'hAA, 8'h55});
    `CHK("prog busy", 2'b10, {write_in_progress, write_enable_latch})
    wait_idle();
    u_host.frame({OP_SR_READ, 8'h00, 8'h23, 8'hFF, 8'h00}, 2, rx);
    `CHK("last byte", 8'hAA, rx[0])
    `CHK("wrapped", 8'h5A, rx[1])
    u_host.frame({OP_SR_READ, 8'h00, 8'h23, 8'h00, 8'h00}, 1, rx);
    `CHK("page wrap", 8'h55, rx[0])
    $display("security register test done");
  endtask

  task automatic t_susp();
    logic [7:0] ops[2] = '{OP_SE, OP_PP};
    logic [7:0] bad[2] = '{OP_SR_ERASE, OP_SR_PROG};
    send({OP_SUSP});
    `CHK("idle suspend", 1'b0, esus | psus)
    for (int i = 0; i < 2; i++)
    begin
      send({OP_WRITE_ENABLE_CMD});
      op4(ops[i], 8'h00, i[0]);
      send({OP_SUSP});
      `CHK("held", 3'b100, {i ? psus : esus, write_in_progress, i ? esus : psus})
      send({OP_WRITE_ENABLE_CMD});
      op4(bad[i], 8'h10, i[0]);
      `CHK("refused", 1'b0, write_in_progress)
      send({OP_RESUME});
      `CHK("resumed", 3'b100, {write_in_progress, esus, psus})
      wait_idle();
    end
    $display("suspend test done");
  endtask

  task automatic t_rst();
    int p;
    p = pulses;
    crm <= 1'b1;
    send({OP_RST_EN});
    send({OP_RST});
    `CHK("crm holds", p, pulses)
    crm <= 1'b0;
    send({OP_WRITE_ENABLE_CMD});
    op4(OP_SE, 8'h00, 1'b0);
    `CHK("busy first", 1'b1, write_in_progress)
    send({OP_RST_EN});
    send({OP_RST});
    `CHK("reset taken", p + 1, pulses)
    `CHK("reset clears", 2'b00, {write_in_progress, write_enable_latch})
    send({OP_WRITE_ENABLE_CMD});
    `CHK("recovering", 1'b0, write_enable_latch)
    repeat (300) @(posedge clk);
    send({OP_WRITE_ENABLE_CMD});
    send({OP_RST_EN});
    send({OP_SUSP});
    send({OP_RST});
    `CHK("split pair", p + 1, pulses)
    `CHK("latch kept", 1'b1, write_enable_latch)
    $display("reset test done");
  endtask

  task automatic t_dpd();
    int p;
    p = pulses;
    send({OP_WRITE_ENABLE_CMD});
    send({OP_CE2});
    send({OP_DPD});
    `CHK("dpd busy", 2'b01, {dpd, write_in_progress})
    send({OP_SUSP});
    `CHK("no chip hold", 2'b01, {esus, write_in_progress})
    wait_idle();
    `CHK("standby", 1'b1, stby)
    send({OP_DPD});
    `CHK("in dpd", 2'b10, {dpd, stby})
    send({OP_WRITE_ENABLE_CMD});
    `CHK("dpd deaf", 1'b0, write_enable_latch)
    send({OP_RDP});
    // host keeps select high while the device wakes
    repeat (1000) @(posedge clk);
    send({OP_WRITE_ENABLE_CMD});
    `CHK("woken", 2'b01, {dpd, write_enable_latch})
    send({OP_DPD});
    send({OP_RST_EN});
    send({OP_RST});
    `CHK("reset wakes", {p + 1, 1'b0}, {pulses, dpd})
    $display("power-down test done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // about 11k cycles expected; cut off at 50k
  initial
  begin
    #1000000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    lock = 3'h0;
    crm = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_uid();
    t_sec();
    t_susp();
    t_rst();
    t_dpd();
    report_and_stop();
  end
endmodule // sfs_flash_seq_tb
`default_nettype wire

// File: sfs_host_model.sv
// serial host model, mode 0, whole bytes msb first
`timescale 1ns/1ps
`default_nettype none

module sfs_host_model (
  input wire logic clk_i, // system clock
  input wire logic so_i, // data from device
  output logic cs_n_o, // chip select, active low
  output logic sclk_o, // serial clock, still between frames
  output logic si_o // data to device
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  // ------------------------------------------------------------------
  // frame: send tx, then clock in nrd bytes; 8 clk per serial bit
  // ------------------------------------------------------------------
  task automatic frame(input logic [7:0] tx[$], input int nrd,
                       output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < tx.size() + nrd; i++)
    begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--)
      begin
        sclk_o <= 1'b0;
        si_o <= b[k];
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        // sampled late in the bit, well after the device's fall update
        b[k] = so_i;
      end
      if (i >= tx.size())
        rx.push_back(b);
    end
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule // sfs_host_model
`default_nettype wire

// File: sfs_pin_sync.sv
// pin synchroniser and edge finder for the serial link
`timescale 1ns/1ps
`default_nettype none

module sfs_pin_sync (
  input wire logic clk_i,       // system clock
  input wire logic rst_n_i,     // async reset, active low
  input wire logic cs_n_i,      // chip select pin, active low
  input wire logic sclk_i,      // serial clock pin
  input wire logic si_i,        // serial data in pin
  output logic cs_n_o,          // synced chip select
  output logic si_o,            // synced data, aligned to edges
  output logic sclk_rise_o,     // one-cycle pulse on sclk rise
  output logic sclk_fall_o,     // one-cycle pulse on sclk fall
  output logic cs_rise_o,       // one-cycle pulse, frame end
  output logic cs_fall_o        // one-cycle pulse, frame start
);

  logic [2:0] cs_q;
  logic [2:0] ck_q;
  logic [1:0] si_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cs_q <= 3'h7;
      ck_q <= 3'h0;
      si_q <= 2'h0;
    end
    else
    begin
      cs_q <= {cs_q[1:0], cs_n_i};
      ck_q <= {ck_q[1:0], sclk_i};
      si_q <= {si_q[0], si_i};
    end
  end

  assign cs_n_o = cs_q[1];
  assign si_o = si_q[1];
  assign sclk_rise_o = ck_q[1] & ~ck_q[2];
  assign sclk_fall_o = ~ck_q[1] & ck_q[2];
  assign cs_rise_o = cs_q[1] & ~cs_q[2];
  assign cs_fall_o = ~cs_q[1] & cs_q[2];

endmodule // sfs_pin_sync

`default_nettype wire

// File: sfs_pkg.sv
// shared constants, opcodes and mode codes of the flash sequencer
package sfs_pkg;

  // -------------------------------------------------------------------
  // opcodes
  // -------------------------------------------------------------------
  localparam logic [7:0] OP_UID = 8'h4B;
  localparam logic [7:0] OP_SR_ERASE = 8'h44;
  localparam logic [7:0] OP_SR_PROG = 8'h42;
  localparam logic [7:0] OP_SR_READ = 8'h48;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDP = 8'hAB;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hC7;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;

  // -------------------------------------------------------------------
  // frame layout and storage
  // -------------------------------------------------------------------
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_OP_ADDR = 16'h0020;
  localparam logic [12:0] BYTES_PROG_HDR = 13'h0004;
  localparam logic [12:0] BYTES_READ_HDR = 13'h0005;
  localparam int SR_BYTES = 1024;
  localparam int PAGE_BYTES = 256;
  localparam int MEM_BYTES = 3072;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // arbitrary value, stands in for the factory number
  localparam logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ = 50;

  // -------------------------------------------------------------------
  // device mode
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    MD_IDLE = 5'h01,
    MD_BUSY = 5'h02,
    MD_SUSP = 5'h04,
    MD_RECOVER = 5'h08,
    MD_DPD = 5'h10
  } sfs_mode_e;

  // valid security register address: 00h, 1..3, 00b
  function automatic logic secreg_addr_ok(input logic [23:0] a);
    secreg_addr_ok = (a[23:16] == 8'h00) && (a[11:10] == 2'h0) &&
                     (a[15:12] != 4'h0) && (a[15:12] <= 4'h3);
  endfunction

  // security register index 0..2 from address bits 15-12
  function automatic logic [1:0] secreg_sel(input logic [23:0] a);
    logic [3:0] s;
    s = a[15:12] - 4'h1;
    secreg_sel = s[1:0];
  endfunction

endpackage

// File: sfs_seq_sva.sv
// port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none

module sfs_seq_sva (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic cs_n_i, // chip select
  input wire logic so_oe_o, // data drive
  input wire logic write_in_progress_o, // busy
  input wire logic write_enable_latch_o, // latch
  input wire logic erase_suspend_flag_o, // erase held
  input wire logic program_suspend_flag_o, // program held
  input wire logic deep_power_down_o, // power-down
  input wire logic soft_reset_o // reset pulse
);
  wire logic write_in_progress = write_in_progress_o;
  wire logic held = erase_suspend_flag_o | program_suspend_flag_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  wel_drop_a: assert property (
    $rose(write_in_progress) && !$past(held) && !$past(held, 2)
    |-> !write_enable_latch_o) else $error("latch kept at cycle start");
  dpd_idle_a: assert property (
    deep_power_down_o |-> !write_in_progress) else $error("busy in power-down");
  one_hold_a: assert property (
    !(erase_suspend_flag_o && program_suspend_flag_o))
    else $error("both suspend flags set");
  hold_stop_a: assert property (
    held |-> !write_in_progress) else $error("busy while suspended");
  resume_run_a: assert property (
    $fell(held) && !soft_reset_o |-> ##[0:2] write_in_progress)
    else $error("resume did not restart");
  rst_pulse_a: assert property (
    soft_reset_o |=> !soft_reset_o) else $error("reset pulse too long");
  rst_clear_a: assert property (
    soft_reset_o |-> !(write_in_progress || held || write_enable_latch_o ||
    deep_power_down_o)) else $error("state kept over reset");
  oe_idle_a: assert property (
    cs_n_i [*6] |-> !so_oe_o) else $error("so driven while deselected");
endmodule // sfs_seq_sva

bind sfs_flash_seq sfs_seq_sva u_sva (
  .clk_i, .rst_n_i, .cs_n_i, .so_oe_o, .write_in_progress_o,
  .write_enable_latch_o, .erase_suspend_flag_o,
  .program_suspend_flag_o, .deep_power_down_o, .soft_reset_o
);
`default_nettype wire
